// *** commission_pkg.sv ***
// Shared constants for the fieldbus commissioning link and its two ends
package commission_pkg;
	// ------------------------------------------------------------
	// Frame layout and command bytes
	// ------------------------------------------------------------
	localparam int FRAME_W = 64;
	localparam logic [7:0] CMD_UPLOAD_REQ = 8'h40;
	localparam logic [7:0] CMD_UPLOAD_8 = 8'h4F;
	localparam logic [7:0] CMD_UPLOAD_16 = 8'h4B;
	localparam logic [7:0] CMD_DNLOAD_MASK = 8'hE0;
	localparam logic [7:0] CMD_DNLOAD_REQ = 8'h20;
	localparam logic [7:0] CMD_DNLOAD_ACK = 8'h60;
	localparam logic [7:0] CMD_DNLOAD_32 = 8'h23;
	localparam logic [7:0] CMD_ABORT = 8'h80;
	localparam logic [31:0] ABORT_NO_OBJECT = 32'h0602_0000;
	// ------------------------------------------------------------
	// Object indices and subindices
	// ------------------------------------------------------------
	localparam logic [15:0] OBJ_BIT_RATE = 16'h2005;
	localparam logic [15:0] OBJ_SWITCH_OFFSET = 16'h2006;
	localparam logic [15:0] OBJ_NODE_ID = 16'h2009;
	localparam logic [15:0] OBJ_STORE = 16'h1010;
	localparam logic [15:0] OBJ_USER_PROG = 16'h2300;
	localparam logic [15:0] OBJ_CONTROL = 16'h6040;
	localparam logic [15:0] OBJ_STATUS = 16'h6041;
	localparam logic [15:0] OBJ_MODES = 16'h6060;
	localparam logic [15:0] OBJ_TARGET_VEL = 16'h6042;
	localparam logic [7:0] SUB_STORE_COMM = 8'h02;
	localparam logic [7:0] SUB_OFFSET_EN = 8'h01;
	localparam logic [7:0] SUB_OFFSET_VAL = 8'h02;
	localparam logic [31:0] SAVE_SIGNATURE = 32'h6576_6173;
	// ------------------------------------------------------------
	// Switch decoding and defaults
	// ------------------------------------------------------------
	localparam logic [3:0] SW_STORED_FIXED = 4'h0;
	localparam logic [3:0] SW_STORED_OBJ = 4'h8;
	localparam logic [6:0] SW_SUB = 7'h08;
	localparam logic [6:0] NODE_RESET = 7'h01;
	localparam logic [6:0] NODE_OBJ_DEFAULT = 7'h7F;
	localparam logic [7:0] RATE_OBJ_DEFAULT = 8'h87;
	localparam logic [7:0] OFFSET_ON = 8'h01;
	localparam logic [9:0] KBD_FIXED = 10'h3E8;
	// ------------------------------------------------------------
	// Drive control fields
	// ------------------------------------------------------------
	localparam logic [7:0] MODE_AUTOSETUP = 8'hFE;
	localparam logic [7:0] MODE_VELOCITY = 8'h02;
	localparam logic [3:0] CW_ENABLE_OP = 4'hF;
	localparam int CW_MODE_BIT = 4;
	localparam int SW_OP_EN_BIT = 2;
	localparam int SW_INDEX_BIT = 10;
	localparam int SW_DONE_BIT = 12;
	localparam logic [7:0] CAT_DRIVE = 8'h05;
	localparam logic [7:0] CAT_TUNING = 8'h06;
	// ------------------------------------------------------------
	// Host register map
	// ------------------------------------------------------------
	localparam logic [7:0] REG_TARGET = 8'h00;
	localparam logic [7:0] REG_WDATA = 8'h04;
	localparam logic [7:0] REG_CMD = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam int CMD_DN_BIT = 0;
	localparam int CMD_UP_BIT = 1;
	localparam int CMD_NMT_BIT = 2;
endpackage

// *** sdo_link_if.sv ***
// Link between the commissioning master and the drive node
`timescale 1ns/1ps
`default_nettype none
interface sdo_link_if;
	logic req_valid;
	logic [63:0] req_data;
	logic rsp_valid;
	logic [63:0] rsp_data;
	logic nmt_reset_comm;
	modport master (output req_valid, output req_data,
		output nmt_reset_comm, input rsp_valid, input rsp_data);
	modport node (input req_valid, input req_data,
		input nmt_reset_comm, output rsp_valid, output rsp_data);
endinterface
`default_nettype wire

// *** id_rate_resolve.sv ***
// Combinational node identifier and bit rate resolution from switch
`timescale 1ns/1ps
`default_nettype none
module id_rate_resolve
(
	input wire logic [3:0] sw,
	input wire logic [7:0] rate_obj,
	input wire logic [6:0] node_obj,
	input wire logic [7:0] offset_en,
	input wire logic [6:0] offset_val,
	output logic [6:0] node_id,
	output logic [9:0] rate_kbd
);
	logic [9:0] obj_kbd;
	logic [6:0] sw7;

	assign sw7 = {3'h0, sw};

	// Object decode; anything out of range falls back to full speed
	always_comb
	begin
		unique case (rate_obj)
			8'h81: obj_kbd = 10'h00A;
			8'h82: obj_kbd = 10'h014;
			8'h83: obj_kbd = 10'h032;
			8'h84: obj_kbd = 10'h07D;
			8'h85: obj_kbd = 10'h0FA;
			8'h86: obj_kbd = 10'h1F4;
			8'h87: obj_kbd = commission_pkg::KBD_FIXED;
			8'h88: obj_kbd = commission_pkg::KBD_FIXED;
			default: obj_kbd = commission_pkg::KBD_FIXED;
		endcase
	end

	// Switch applied last, over whatever the objects hold
	always_comb
	begin
		if (offset_en == commission_pkg::OFFSET_ON)
		begin
			if (sw == commission_pkg::SW_STORED_FIXED)
			begin
				node_id = node_obj;
				rate_kbd = commission_pkg::KBD_FIXED;
			end
			else
			begin
				node_id = 7'(sw7 + offset_val);
				rate_kbd = obj_kbd;
			end
		end
		else if (!sw[3])
		begin
			node_id = (sw == commission_pkg::SW_STORED_FIXED) ?
				node_obj : sw7;
			rate_kbd = commission_pkg::KBD_FIXED;
		end
		else
		begin
			node_id = (sw == commission_pkg::SW_STORED_OBJ) ?
				node_obj : 7'(sw7 - commission_pkg::SW_SUB);
			rate_kbd = obj_kbd;
		end
	end
endmodule
`default_nettype wire

// *** drive_node.sv ***
// Drive node end: object dictionary, id/rate loader and auto setup control
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Unconfigured: node 1 at 1000 kBd
// - Switch 0 stored id, 1-7 itself; 1 MBd
// - Switch 8 stored id, 9-F minus 8; object rate
// - Rate object 81..88 maps to kBd table
// - Master stores settings with save signature
// - New id and rate apply only on reset or reset-comm
// - Load default, stored, config file, then switch
// - Offset mode only when offset enable is 1
// - Offset mode switch 0: stored id, 1 MBd
// - Offset mode 1-F: switch plus offset
// - Status word upload answered 4B 41 60 00
// - Master selects auto setup mode FE, enables
// - Mode bit 4 starts auto setup when enabled
// - Status bit 12 set when setup done
// - Status bit 10 reports index found
// - Master starts setup only without user program
// - Limit switches stay active during setup
// - Results saved under drive and tuning categories
// - Closed loop refused until setup succeeded
// - Master restarts device after setup
// - Velocity run: mode 2, speed, enable
// - Control word 0 stops the motor
// - Master reads status back after transfers
module drive_node
(
	input wire logic clk,
	input wire logic rst,
	sdo_link_if.node link,
	input wire logic [3:0] hex_config_switch,
	input wire logic cfg_present,
	input wire logic [7:0] cfg_bit_rate,
	input wire logic [6:0] cfg_node_id,
	input wire logic setup_done,
	input wire logic setup_index_found,
	input wire logic closed_loop_req,
	output logic [6:0] node_id_ff,
	output logic [9:0] bit_rate_kbd_ff,
	output logic setup_run_ff,
	output logic limits_active_ff,
	output logic closed_loop_ff,
	output logic motor_run_ff,
	output logic [31:0] target_vel_ff,
	output logic save_pulse_ff,
	output logic [7:0] save_cat_ff
);
	logic [7:0] rate_obj_ff;
	logic [6:0] node_obj_ff;
	logic [7:0] offset_en_ff;
	logic [6:0] offset_val_ff;
	logic [7:0] stored_rate_ff;
	logic [6:0] stored_node_ff;
	logic stored_valid_ff;
	logic apply_ff;
	logic reload_ff;
	logic [15:0] control_ff;
	logic [7:0] modes_ff;
	logic [7:0] user_prog_ff;
	logic setup_ok_ff;
	logic setup_fin_ff;
	logic index_ff;
	logic save_tuning_ff;
	logic rsp_valid_ff;
	logic [63:0] rsp_data_ff;
	logic [7:0] ld_rate;
	logic [6:0] ld_node;
	logic [6:0] res_node;
	logic [9:0] res_kbd;
	logic [7:0] cmd;
	logic [15:0] idx;
	logic [7:0] sub;
	logic [31:0] val;
	logic is_up;
	logic is_dn;
	logic op_en;
	logic [15:0] status;
	logic wr_control;
	logic setup_start;

	// ------------------------------------------------------------
	// Request fields and derived drive state
	// ------------------------------------------------------------
	assign cmd = link.req_data[7:0];
	assign idx = link.req_data[23:8];
	assign sub = link.req_data[31:24];
	assign val = link.req_data[63:32];
	assign is_up = link.req_valid && cmd == commission_pkg::CMD_UPLOAD_REQ;
	assign is_dn = link.req_valid && (cmd & commission_pkg::CMD_DNLOAD_MASK)
		== commission_pkg::CMD_DNLOAD_REQ;
	assign op_en = control_ff[3:0] == commission_pkg::CW_ENABLE_OP;
	assign wr_control = is_dn && idx == commission_pkg::OBJ_CONTROL;
	// Rising mode bit only; a held bit does not restart the run
	assign setup_start = wr_control && val[commission_pkg::CW_MODE_BIT] &&
		!control_ff[commission_pkg::CW_MODE_BIT] && op_en &&
		modes_ff == commission_pkg::MODE_AUTOSETUP &&
		!user_prog_ff[0];
	assign link.rsp_valid = rsp_valid_ff;
	assign link.rsp_data = rsp_data_ff;

	// Status word assembly
	always_comb
	begin
		status = 16'h0000;
		status[commission_pkg::SW_OP_EN_BIT] = op_en;
		status[commission_pkg::SW_DONE_BIT] = setup_fin_ff;
		status[commission_pkg::SW_INDEX_BIT] = index_ff;
	end

	// ------------------------------------------------------------
	// Load chain for the communication settings
	// ------------------------------------------------------------
	always_comb
	begin
		ld_rate = commission_pkg::RATE_OBJ_DEFAULT;
		ld_node = commission_pkg::NODE_OBJ_DEFAULT;
		if (stored_valid_ff)
		begin
			ld_rate = stored_rate_ff;
			ld_node = stored_node_ff;
		end
		if (cfg_present)
		begin
			ld_rate = cfg_bit_rate;
			ld_node = cfg_node_id;
		end
	end

	id_rate_resolve resolve
	(
		.sw(hex_config_switch),
		.rate_obj(rate_obj_ff),
		.node_obj(node_obj_ff),
		.offset_en(offset_en_ff),
		.offset_val(offset_val_ff),
		.node_id(res_node),
		.rate_kbd(res_kbd)
	);

	// Reset and reset-comm reload objects; outputs follow one cycle later,
	// so the resolver never sees the objects as they were before a reload
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			reload_ff <= 1'b1;
			apply_ff <= 1'b0;
		end
		else
		begin
			reload_ff <= 1'b0;
			apply_ff <= link.nmt_reset_comm || reload_ff;
		end
	end

	// Communication objects: written live; rate and node id reloaded on reset-comm or after reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rate_obj_ff <= commission_pkg::RATE_OBJ_DEFAULT;
			node_obj_ff <= commission_pkg::NODE_OBJ_DEFAULT;
			offset_en_ff <= 8'h00;
			offset_val_ff <= 7'h00;
		end
		else if (link.nmt_reset_comm || reload_ff)
		begin
			rate_obj_ff <= ld_rate;
			node_obj_ff <= ld_node;
		end
		else if (is_dn)
		begin
			if (idx == commission_pkg::OBJ_BIT_RATE)
				rate_obj_ff <= val[7:0];
			if (idx == commission_pkg::OBJ_NODE_ID)
				node_obj_ff <= val[6:0];
			if (idx == commission_pkg::OBJ_SWITCH_OFFSET &&
				sub == commission_pkg::SUB_OFFSET_EN)
				offset_en_ff <= val[7:0];
			if (idx == commission_pkg::OBJ_SWITCH_OFFSET &&
				sub == commission_pkg::SUB_OFFSET_VAL)
				offset_val_ff <= val[6:0];
		end
	end

	// Persistent copy taken only on the save signature
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			stored_rate_ff <= commission_pkg::RATE_OBJ_DEFAULT;
			stored_node_ff <= commission_pkg::NODE_OBJ_DEFAULT;
			stored_valid_ff <= 1'b0;
		end
		else if (is_dn && idx == commission_pkg::OBJ_STORE &&
			sub == commission_pkg::SUB_STORE_COMM &&
			val == commission_pkg::SAVE_SIGNATURE)
		begin
			stored_rate_ff <= rate_obj_ff;
			stored_node_ff <= node_obj_ff;
			stored_valid_ff <= 1'b1;
		end
	end

	// Active settings change only after an apply
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			node_id_ff <= commission_pkg::NODE_RESET;
			bit_rate_kbd_ff <= commission_pkg::KBD_FIXED;
		end
		else if (apply_ff)
		begin
			node_id_ff <= res_node;
			bit_rate_kbd_ff <= res_kbd;
		end
	end

	// ------------------------------------------------------------
	// Drive control objects
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			control_ff <= 16'h0000;
			modes_ff <= 8'h00;
			user_prog_ff <= 8'h00;
			target_vel_ff <= 32'h0000_0000;
		end
		else if (is_dn)
		begin
			if (wr_control)
				control_ff <= val[15:0];
			if (idx == commission_pkg::OBJ_MODES)
				modes_ff <= val[7:0];
			if (idx == commission_pkg::OBJ_USER_PROG)
				user_prog_ff <= val[7:0];
			if (idx == commission_pkg::OBJ_TARGET_VEL)
				target_vel_ff <= val;
		end
	end

	// Auto setup run and its outcome; done input wins over a new start
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			setup_run_ff <= 1'b0;
			setup_fin_ff <= 1'b0;
			setup_ok_ff <= 1'b0;
			index_ff <= 1'b0;
		end
		else if (setup_run_ff && setup_done)
		begin
			setup_run_ff <= 1'b0;
			setup_fin_ff <= 1'b1;
			setup_ok_ff <= 1'b1;
			index_ff <= setup_index_found;
		end
		else if (setup_run_ff && !op_en)
			setup_run_ff <= 1'b0;
		else if (setup_start)
		begin
			setup_run_ff <= 1'b1;
			setup_fin_ff <= 1'b0;
		end
	end

	// Saves results in two categories on consecutive cycles
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			save_pulse_ff <= 1'b0;
			save_cat_ff <= 8'h00;
			save_tuning_ff <= 1'b0;
		end
		else
		begin
			save_pulse_ff <= (setup_run_ff && setup_done) || save_tuning_ff;
			save_tuning_ff <= setup_run_ff && setup_done;
			if (setup_run_ff && setup_done)
				save_cat_ff <= commission_pkg::CAT_DRIVE;
			else if (save_tuning_ff)
				save_cat_ff <= commission_pkg::CAT_TUNING;
		end
	end

	// Motion permissions; limits active whenever out of reset, setup included
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			closed_loop_ff <= 1'b0;
			motor_run_ff <= 1'b0;
			limits_active_ff <= 1'b0;
		end
		else
		begin
			limits_active_ff <= 1'b1;
			closed_loop_ff <= closed_loop_req && setup_ok_ff;
			motor_run_ff <= op_en && control_ff != 16'h0000 &&
				modes_ff == commission_pkg::MODE_VELOCITY;
		end
	end

	// ------------------------------------------------------------
	// Responses, one cycle after each request
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rsp_valid_ff <= 1'b0;
			rsp_data_ff <= 64'h0;
		end
		else
		begin
			rsp_valid_ff <= link.req_valid;
			if (is_dn)
				rsp_data_ff <= {32'h0, sub, idx, commission_pkg::CMD_DNLOAD_ACK};
			else if (is_up && idx == commission_pkg::OBJ_STATUS)
				rsp_data_ff <= {16'h0, status, sub, idx,
					commission_pkg::CMD_UPLOAD_16};
			else if (is_up && idx == commission_pkg::OBJ_CONTROL)
				rsp_data_ff <= {16'h0, control_ff, sub, idx,
					commission_pkg::CMD_UPLOAD_16};
			else if (is_up && idx == commission_pkg::OBJ_BIT_RATE)
				rsp_data_ff <= {24'h0, rate_obj_ff, sub, idx,
					commission_pkg::CMD_UPLOAD_8};
			else if (is_up && idx == commission_pkg::OBJ_NODE_ID)
				rsp_data_ff <= {25'h0, node_obj_ff, sub, idx,
					commission_pkg::CMD_UPLOAD_8};
			else if (is_up && idx == commission_pkg::OBJ_MODES)
				rsp_data_ff <= {24'h0, modes_ff, sub, idx,
					commission_pkg::CMD_UPLOAD_8};
			else if (link.req_valid)
				rsp_data_ff <= {commission_pkg::ABORT_NO_OBJECT, sub, idx,
					commission_pkg::CMD_ABORT};
		end
	end
endmodule
`default_nettype wire

// *** sdo_master.sv ***
// Master end: register-driven single transfer engine over the link
`timescale 1ns/1ps
`default_nettype none
module sdo_master
(
	input wire logic clk,
	input wire logic rst,
	sdo_link_if.master link,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata_ff
);
	logic [23:0] target_ff;
	logic [31:0] wdata_ff;
	logic [31:0] resp_ff;
	logic busy_ff;
	logic done_ff;
	logic abort_ff;
	logic req_valid_ff;
	logic [63:0] req_data_ff;
	logic nmt_ff;
	logic go_dn;
	logic go_up;

	assign go_dn = wr && addr == commission_pkg::REG_CMD &&
		wdata[commission_pkg::CMD_DN_BIT] && !busy_ff;
	assign go_up = wr && addr == commission_pkg::REG_CMD &&
		wdata[commission_pkg::CMD_UP_BIT] && !go_dn && !busy_ff;
	assign link.req_valid = req_valid_ff;
	assign link.req_data = req_data_ff;
	assign link.nmt_reset_comm = nmt_ff;

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			target_ff <= 24'h0;
			wdata_ff <= 32'h0;
		end
		else if (wr && addr == commission_pkg::REG_TARGET)
			target_ff <= wdata[23:0];
		else if (wr && addr == commission_pkg::REG_WDATA)
			wdata_ff <= wdata;
	end

	// Frame launch; one outstanding transfer, later starts ignored
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			req_valid_ff <= 1'b0;
			req_data_ff <= 64'h0;
			nmt_ff <= 1'b0;
		end
		else
		begin
			req_valid_ff <= go_dn || go_up;
			nmt_ff <= wr && addr == commission_pkg::REG_CMD &&
				wdata[commission_pkg::CMD_NMT_BIT];
			if (go_dn)
				req_data_ff <= {wdata_ff, target_ff,
					commission_pkg::CMD_DNLOAD_32};
			else if (go_up)
				req_data_ff <= {32'h0, target_ff,
					commission_pkg::CMD_UPLOAD_REQ};
		end
	end

	// Completion flags; a response beats a software clear
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			abort_ff <= 1'b0;
			resp_ff <= 32'h0;
		end
		else if (busy_ff && link.rsp_valid)
		begin
			busy_ff <= 1'b0;
			done_ff <= 1'b1;
			abort_ff <= link.rsp_data[7:0] == commission_pkg::CMD_ABORT;
			resp_ff <= link.rsp_data[63:32];
		end
		else if (go_dn || go_up)
		begin
			busy_ff <= 1'b1;
			done_ff <= 1'b0;
			abort_ff <= 1'b0;
		end
		else if (wr && addr == commission_pkg::REG_STATUS)
		begin
			done_ff <= done_ff & ~wdata[1];
			abort_ff <= abort_ff & ~wdata[2];
		end
	end

	// Read data stands the cycle after the strobe only
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata_ff <= 32'h0;
		else if (!rd)
			rdata_ff <= 32'h0;
		else
		begin
			unique case (addr)
				commission_pkg::REG_TARGET: rdata_ff <= {8'h0, target_ff};
				commission_pkg::REG_WDATA: rdata_ff <= wdata_ff;
				commission_pkg::REG_STATUS:
					rdata_ff <= {29'h0, abort_ff, done_ff, busy_ff};
				commission_pkg::REG_RDATA: rdata_ff <= resp_ff;
				default: rdata_ff <= 32'h0;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** commission_assertions.sv ***
// Link-level checks between the commissioning master and the drive node
`timescale 1ns/1ps
`default_nettype none
module commission_assertions
(
	input wire logic clk,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic [63:0] req_data,
	input wire logic rsp_valid,
	input wire logic [63:0] rsp_data,
	input wire logic nmt_reset_comm
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// ------------------------------------------------------------
	// Request decoding
	// ------------------------------------------------------------
	logic up_req;
	logic known_up;
	logic dn_req;
	assign up_req = req_valid && req_data[7:0] == 8'h40;
	assign known_up = req_data[23:8] inside {16'h6041, 16'h6040, 16'h2005,
		16'h2009, 16'h6060};
	assign dn_req = req_valid && req_data[7:5] == 3'h1;
	// ------------------------------------------------------------
	// Link properties
	// ------------------------------------------------------------
	a_answer_next: assert property (req_valid |=> rsp_valid)
		else $error("No answer one cycle after a request");
	a_answer_caused: assert property (rsp_valid |-> $past(req_valid))
		else $error("Answer without a request");
	a_req_single: assert property (req_valid |=> !req_valid)
		else $error("Request longer than one cycle");
	a_rsp_hold: assert property (!rsp_valid |-> $stable(rsp_data))
		else $error("Answer data moved between answers");
	a_status_frame: assert property (up_req && req_data[31:8] == 24'h006041
		|=> rsp_data[31:0] == 32'h0060414B && rsp_data[63:48] == 16'h0000)
		else $error("Status word answer malformed");
	a_rate_frame: assert property (up_req && req_data[23:8] == 16'h2005
		|=> rsp_data[7:0] == 8'h4F && rsp_data[63:40] == 24'h000000)
		else $error("Rate object answer malformed");
	a_abort_unknown: assert property (up_req && !known_up
		|=> rsp_data[7:0] == 8'h80 && rsp_data[63:32] == 32'h06020000)
		else $error("Unknown object not aborted");
	a_dnload_ack: assert property (dn_req
		|=> rsp_data[7:0] == 8'h60 && rsp_data[31:8] == $past(req_data[31:8]))
		else $error("Download not acknowledged");
	a_nmt_pulse: assert property (nmt_reset_comm |=> !nmt_reset_comm)
		else $error("Reset command longer than one cycle");
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench: master and drive node joined over the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk;
	logic rst;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic [3:0] hex_config_switch;
	logic cfg_present;
	logic [7:0] cfg_bit_rate;
	logic [6:0] cfg_node_id;
	logic setup_done;
	logic setup_index_found;
	logic closed_loop_req;
	logic [6:0] node_id;
	logic [9:0] rate;
	logic run;
	logic limits;
	logic closed;
	logic motor;
	logic [31:0] tvel;
	logic save_p;
	logic [7:0] save_c;
	logic [31:0] v;
	logic [31:0] st;
	int n_errors;
	int total_checks;
	sdo_link_if link();
	sdo_master i_sdo_master(.clk(clk), .rst(rst), .link(link), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata));
	drive_node i_drive_node(.clk(clk), .rst(rst), .link(link),
		.hex_config_switch(hex_config_switch), .cfg_present(cfg_present),
		.cfg_bit_rate(cfg_bit_rate), .cfg_node_id(cfg_node_id),
		.setup_done(setup_done), .setup_index_found(setup_index_found),
		.closed_loop_req(closed_loop_req), .node_id_ff(node_id),
		.bit_rate_kbd_ff(rate), .setup_run_ff(run), .limits_active_ff(limits),
		.closed_loop_ff(closed), .motor_run_ff(motor), .target_vel_ff(tvel),
		.save_pulse_ff(save_p), .save_cat_ff(save_c));
	commission_assertions i_commission_assertions(.clk(clk), .rst(rst),
		.req_valid(link.req_valid), .req_data(link.req_data),
		.rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
		.nmt_reset_comm(link.nmt_reset_comm));
	// ------------------------------------------------------------
	// Clock and watchdog
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Run needs about 900 cycles; a hang is cut well beyond that
	initial
	begin
		#400000;
		n_errors++;
		conclude();
	end
	// ------------------------------------------------------------
	// Access and compare tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic get(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// One transfer: target, data, command, poll for done or abort, clear
	task automatic xfer(input logic [7:0] c, input logic [15:0] idx,
		input logic [7:0] sb, input logic [31:0] d);
		int n;
		put(commission_pkg::REG_TARGET, {8'h00, sb, idx});
		put(commission_pkg::REG_WDATA, d);
		put(commission_pkg::REG_CMD, {24'h0, c});
		st = 32'h0;
		n = 0;
		while (st[2:1] === 2'b00 && n < 20)
		begin
			get(commission_pkg::REG_STATUS, st);
			n++;
		end
		chk({31'h0, n < 20}, 32'h1);
		get(commission_pkg::REG_RDATA, v);
		put(commission_pkg::REG_STATUS, 32'h6);
	endtask
	task automatic dn(input logic [15:0] idx, input logic [7:0] sb,
		input logic [31:0] d);
		xfer(8'h01, idx, sb, d);
	endtask
	task automatic save();
		dn(16'h1010, 8'h02, commission_pkg::SAVE_SIGNATURE);
	endtask
	// Reset-communication, then the resolved id and rate are compared
	task automatic resolve(input logic [3:0] s, input logic [6:0] en,
		input logic [9:0] er);
		hex_config_switch <= s;
		put(commission_pkg::REG_CMD, 32'h4);
		repeat (3) @(posedge clk);
		#1;
		chk({25'h0, node_id}, {25'h0, en});
		chk({22'h0, rate}, {22'h0, er});
	endtask
	function automatic logic [9:0] kbd(input logic [7:0] c);
		case (c)
			8'h81: kbd = 10'h00A;
			8'h82: kbd = 10'h014;
			8'h83: kbd = 10'h032;
			8'h84: kbd = 10'h07D;
			8'h85: kbd = 10'h0FA;
			8'h86: kbd = 10'h1F4;
			default: kbd = 10'h3E8;
		endcase
	endfunction
	task automatic conclude();
		if (n_errors == 0 && total_checks > 0)
		begin
			$display("Simulation passed");
		end
		else
		begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		{addr, wdata, wr, rd, cfg_present, cfg_bit_rate, cfg_node_id} = '0;
		{setup_done, setup_index_found, closed_loop_req} = '0;
		hex_config_switch = 4'h1;
		n_errors = 0;
		total_checks = 0;
		repeat (4) @(posedge clk);
		chk({15'h0, node_id, rate}, {15'h0, 7'h01, 10'h3E8});
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk({15'h0, node_id, rate}, {15'h0, 7'h01, 10'h3E8});
		resolve(4'h8, 7'h7F, 10'h3E8);
		dn(16'h2005, 8'h00, 32'h84);
		dn(16'h2009, 8'h00, 32'h22);
		xfer(8'h02, 16'h2005, 8'h00, 32'h0);
		chk(v, 32'h84);
		chk({25'h0, node_id}, 32'h7F);
		resolve(4'h8, 7'h7F, 10'h3E8);
		dn(16'h2005, 8'h00, 32'h84);
		dn(16'h2009, 8'h00, 32'h22);
		save();
		resolve(4'h8, 7'h22, 10'h07D);
		for (int s = 0; s < 16; s++)
			resolve(s[3:0], (s == 0 || s == 8) ? 7'h22 : (s < 8 ? s[6:0] :
				s[6:0] - 7'h08), s < 8 ? 10'h3E8 : 10'h07D);
		for (int c = 8'h80; c < 8'h8A; c++)
		begin
			dn(16'h2005, 8'h00, c);
			save();
			resolve(4'h8, 7'h22, kbd(c[7:0]));
		end
		cfg_present <= 1'b1;
		cfg_bit_rate <= 8'h82;
		cfg_node_id <= 7'h33;
		resolve(4'h8, 7'h33, 10'h014);
		resolve(4'h1, 7'h01, 10'h3E8);
		cfg_present <= 1'b0;
		dn(16'h2005, 8'h00, 32'h83);
		save();
		dn(16'h2006, 8'h01, 32'h2);
		dn(16'h2006, 8'h02, 32'h10);
		resolve(4'h9, 7'h01, 10'h032);
		dn(16'h2006, 8'h01, 32'h1);
		resolve(4'h0, 7'h33, 10'h3E8);
		resolve(4'hF, 7'h1F, 10'h032);
		dn(16'h2006, 8'h02, 32'h7A);
		resolve(4'h9, 7'h03, 10'h032);
		xfer(8'h02, 16'h1234, 8'h00, 32'h0);
		chk({31'h0, st[2]}, 32'h1);
		chk(v, 32'h06020000);
		xfer(8'h02, 16'h6041, 8'h00, 32'h0);
		chk(v & 32'hFFFF_1404, 32'h0);
		closed_loop_req <= 1'b1;
		dn(16'h6040, 8'h00, 32'h0F);
		dn(16'h6040, 8'h00, 32'h1F);
		chk({closed, run}, 32'h0);
		dn(16'h6040, 8'h00, 32'h0F);
		dn(16'h6060, 8'h00, 32'hFE);
		dn(16'h2300, 8'h00, 32'h1);
		dn(16'h6040, 8'h00, 32'h1F);
		chk({31'h0, run}, 32'h0);
		dn(16'h6040, 8'h00, 32'h0F);
		dn(16'h2300, 8'h00, 32'h0);
		dn(16'h6040, 8'h00, 32'h1F);
		chk({limits, run}, 32'h3);
		@(posedge clk);
		setup_done <= 1'b1;
		setup_index_found <= 1'b1;
		@(posedge clk);
		setup_done <= 1'b0;
		#1;
		chk({31'h0, run}, 32'h0);
		chk({save_p, save_c}, {1'b1, 8'h05});
		@(posedge clk);
		#1;
		chk({save_p, save_c}, {1'b1, 8'h06});
		@(posedge clk);
		#1;
		chk({31'h0, save_p}, 32'h0);
		xfer(8'h02, 16'h6041, 8'h00, 32'h0);
		chk(v & 32'hFFFF_1404, 32'h1404);
		chk({31'h0, closed}, 32'h1);
		resolve(4'h9, 7'h03, 10'h032);
		dn(16'h6060, 8'h00, 32'h02);
		dn(16'h6042, 8'h00, 32'h100);
		dn(16'h6040, 8'h00, 32'h0F);
		chk({31'h0, motor}, 32'h1);
		chk(tvel, 32'h100);
		dn(16'h6040, 8'h00, 32'h0);
		chk({31'h0, motor}, 32'h0);
		conclude();
	end
endmodule
`default_nettype wire
